// file: rtl/bfsp_consts.vh
// Constants of the boot flash section protection block.
// Assumes inclusion by bare name from rtl/.
`ifndef BFSP_CONSTS_VH
`define BFSP_CONSTS_VH

// Register byte offsets
`define BFSP_OFS_CTRL        8'h00
`define BFSP_OFS_LOCK        8'h04
`define BFSP_OFS_CFG         8'h08

// Control register fields
`define BFSP_CTRL_EN         0
`define BFSP_CTRL_ERASE      1
`define BFSP_CTRL_WRITE      2
`define BFSP_CTRL_LOCKSET    3
`define BFSP_CTRL_BUSYCLR    4
`define BFSP_CTRL_BUSY       6
`define BFSP_CTRL_REFUSED    7
`define BFSP_CTRL_CMD_W      5

// Lock register fields (1 = unprogrammed)
`define BFSP_LOCK_APP_LO     1
`define BFSP_LOCK_APP_HI     2
`define BFSP_LOCK_BOOT_LO    3
`define BFSP_LOCK_BOOT_HI    4
`define BFSP_LOCK_RST        5'h1f

// Configuration register fields
`define BFSP_CFG_SIZE_LO     0
`define BFSP_CFG_RSTSEL      2
`define BFSP_CFG_HALT        3
`define BFSP_CFG_RUN         4

// Cycles after a command write in which a store is accepted
`define BFSP_SPM_WINDOW      3'h4

// AXI responses
`define BFSP_RESP_OKAY       2'h0
`define BFSP_RESP_SLVERR     2'h2

`endif

// file: rtl/bfsp_top.v
// Boot flash section protection: guards store/load program memory access.
// Assumes core, flash and bus share clock; flash_done pulses at op end.
//
// How it works
// - Stores fetched from application region are refused
// - Boot region stores may target whole flash
// - Boundary comes only from size fuses
// - Fixed halting region independent of fuse boundary
// - Concurrent region programming leaves fetches running
// - Halting region programming stalls core throughout
// - Concurrent region unreadable during programming
// - Busy bit reads one while region blocked
// - Boot region lies inside halting region
// - Reset vector picked by reset select fuse
// - Software has no way to alter fuses
// - Lock bits only program; chip erase restores
// - General lock modes ignored for store/load
// - Application lock pair guards application region
// - Modes one to four for application
// - Mode three blocks stores and boot loads
// - Mode four blocks boot-side loads and, with vectors in boot, interrupts in application
// - Store accepted only within four cycles after command
// - Boot lock pair mirrors modes on boot
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`include "bfsp_consts.vh"

module bfsp_top #(
  parameter ADDR_W     = 14,
  parameter BOOT_MIN   = 256,
  parameter HALTING_REGION_WORDS = 2048
) (
  input  wire              clock,
  input  wire              sys_rst,
  // AXI4-Lite slave
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Fuses and chip erase from the external programming interface
  input  wire [1:0]        boot_region_size_fuses,
  input  wire              reset_vector_select_fuse,
  input  wire              chip_erase,
  // Processor core
  input  wire [ADDR_W-1:0] exec_pc,
  input  wire              vectors_in_boot,
  input  wire              spm_req,
  input  wire [ADDR_W-1:0] spm_addr,
  input  wire [7:0]        spm_data,
  input  wire              lpm_req,
  input  wire [ADDR_W-1:0] lpm_addr,
  output reg               lpm_grant_ff,
  output reg               lpm_deny_ff,
  output reg               cpu_halt_ff,
  output reg               irq_block_ff,
  output reg  [ADDR_W-1:0] reset_vector_ff,
  // Flash array
  output reg               flash_start_ff,
  output reg               flash_erase_ff,
  output reg  [ADDR_W-1:0] flash_addr_ff,
  input  wire              flash_done
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  localparam [ADDR_W-1:0] BOOT_MIN_W = BOOT_MIN[ADDR_W-1:0];
  localparam [ADDR_W-1:0] HALTING_REGION_W     = HALTING_REGION_WORDS[ADDR_W-1:0];
  localparam [ADDR_W-1:0] ZERO_A     = {ADDR_W{1'b0}};

  reg                       state_ff;
  reg [`BFSP_CTRL_CMD_W-1:0] cmd_ff;
  reg [2:0]                 window_ff;
  reg                       busy_ff;
  reg                       refused_ff;
  reg                       halt_op_ff;
  reg [4:0]                 lock_ff;
  reg [7:0]                 awaddr_ff;
  reg [31:0]                wdata_ff;
  reg [3:0]                 wstrb_ff;
  reg                       aw_got_ff;
  reg                       w_got_ff;

  // Region decoding
  wire [1:0]        size_shift = ~boot_region_size_fuses;
  wire [ADDR_W-1:0] boot_start = ZERO_A - (BOOT_MIN_W << size_shift);
  // HALTING_REGION_WORDS must cover the largest boot size so boot stays halting
  wire [ADDR_W-1:0] halt_start = ZERO_A - HALTING_REGION_W;
  wire exec_boot = (exec_pc >= boot_start);
  wire spm_tgt_boot  = (spm_addr >= boot_start);
  wire spm_tgt_halt  = (spm_addr >= halt_start);
  wire lpm_tgt_boot  = (lpm_addr >= boot_start);
  wire lpm_tgt_halt  = (lpm_addr >= halt_start);

  wire app_lo  = lock_ff[`BFSP_LOCK_APP_LO];
  wire app_hi  = lock_ff[`BFSP_LOCK_APP_HI];
  wire boot_lo = lock_ff[`BFSP_LOCK_BOOT_LO];
  wire boot_hi = lock_ff[`BFSP_LOCK_BOOT_HI];

  // Store write blocked when low lock bit programmed (modes 2 and 3)
  wire spm_lock_block = spm_tgt_boot ? ~boot_lo : ~app_lo;
  // Cross-region load blocked when high lock bit programmed (modes 3, 4)
  wire lpm_lock_block = lpm_tgt_boot ? (~exec_boot & ~boot_hi) :
                        (exec_boot & ~app_hi);
  wire lpm_rww_block  = busy_ff & ~lpm_tgt_halt;

  wire cmd_en     = cmd_ff[`BFSP_CTRL_EN];
  wire cmd_prog   = cmd_ff[`BFSP_CTRL_ERASE] | cmd_ff[`BFSP_CTRL_WRITE];
  wire cmd_lock   = cmd_ff[`BFSP_CTRL_LOCKSET];
  wire cmd_bclr   = cmd_ff[`BFSP_CTRL_BUSYCLR];
  wire in_window  = cmd_en & (window_ff != 3'h0) & (state_ff == ST_IDLE);
  // Store only from boot region; general lock modes play no part
  wire spm_ok     = spm_req & in_window & exec_boot;
  wire prog_go    = spm_ok & cmd_prog & ~spm_lock_block;
  wire prog_ref   = spm_req & (~in_window | ~exec_boot |
                    (cmd_prog & spm_lock_block));
  wire lock_go    = spm_ok & cmd_lock & ~cmd_prog;
  wire bclr_go    = spm_ok & cmd_bclr & ~cmd_prog;

  // AXI write channel
  wire wr_fire    = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire wr_ctrl    = wr_fire & (awaddr_ff == `BFSP_OFS_CTRL) & wstrb_ff[0];
  wire wr_known   = (awaddr_ff == `BFSP_OFS_CTRL) |
                    (awaddr_ff == `BFSP_OFS_LOCK) |
                    (awaddr_ff == `BFSP_OFS_CFG);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BFSP_RESP_OKAY;
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_got_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_got_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `BFSP_RESP_OKAY : `BFSP_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == `BFSP_OFS_CTRL) begin
      rd_mux[`BFSP_CTRL_CMD_W-1:0] = cmd_ff;
      rd_mux[`BFSP_CTRL_BUSY]      = busy_ff;
      rd_mux[`BFSP_CTRL_REFUSED]   = refused_ff;
    end else if (s_axi_araddr == `BFSP_OFS_LOCK) begin
      rd_mux[4:0] = lock_ff;
    end else if (s_axi_araddr == `BFSP_OFS_CFG) begin
      rd_mux[`BFSP_CFG_SIZE_LO+1:`BFSP_CFG_SIZE_LO] = boot_region_size_fuses;
      rd_mux[`BFSP_CFG_RSTSEL] = reset_vector_select_fuse;
      rd_mux[`BFSP_CFG_HALT]   = cpu_halt_ff;
      rd_mux[`BFSP_CFG_RUN]    = state_ff;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BFSP_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `BFSP_RESP_OKAY : `BFSP_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Command, window and programming sequence
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff       <= ST_IDLE;
      cmd_ff         <= {`BFSP_CTRL_CMD_W{1'b0}};
      window_ff      <= 3'h0;
      busy_ff        <= 1'b0;
      refused_ff     <= 1'b0;
      halt_op_ff     <= 1'b0;
      cpu_halt_ff    <= 1'b0;
      flash_start_ff <= 1'b0;
      flash_erase_ff <= 1'b0;
      flash_addr_ff  <= ZERO_A;
    end else begin
      flash_start_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (prog_go) begin
            state_ff       <= ST_RUN;
            flash_start_ff <= 1'b1;
            flash_erase_ff <= cmd_ff[`BFSP_CTRL_ERASE];
            flash_addr_ff  <= spm_addr;
            window_ff      <= 3'h0;
            halt_op_ff     <= spm_tgt_halt;
            cpu_halt_ff    <= spm_tgt_halt;
            busy_ff        <= busy_ff | ~spm_tgt_halt;
          end else if (wr_ctrl) begin
            cmd_ff    <= wdata_ff[`BFSP_CTRL_CMD_W-1:0];
            window_ff <= wdata_ff[`BFSP_CTRL_EN] ? `BFSP_SPM_WINDOW : 3'h0;
          end else if (spm_ok | (window_ff == 3'h1)) begin
            cmd_ff    <= {`BFSP_CTRL_CMD_W{1'b0}};
            window_ff <= 3'h0;
          end else if (window_ff != 3'h0) begin
            window_ff <= window_ff - 3'h1;
          end
          if (bclr_go & ~prog_go) begin
            busy_ff <= 1'b0;
          end
        end
        ST_RUN: begin
          if (flash_done) begin
            state_ff    <= ST_IDLE;
            cmd_ff      <= {`BFSP_CTRL_CMD_W{1'b0}};
            cpu_halt_ff <= 1'b0;
            halt_op_ff  <= 1'b0;
          end else begin
            cpu_halt_ff <= halt_op_ff;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      // Refusal sticky; a new refusal wins over the write clear
      if (prog_ref) begin
        refused_ff <= 1'b1;
      end else if (wr_ctrl) begin
        refused_ff <= 1'b0;
      end
    end
  end

  // Lock bits: software may only program, chip erase restores
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lock_ff <= `BFSP_LOCK_RST;
    end else if (chip_erase) begin
      lock_ff <= `BFSP_LOCK_RST;
    end else if (lock_go) begin
      lock_ff <= lock_ff & (spm_data[4:0] | 5'h01);
    end
  end

  // Load checks, interrupt blocking and reset vector
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lpm_grant_ff    <= 1'b0;
      lpm_deny_ff     <= 1'b0;
      irq_block_ff    <= 1'b0;
      reset_vector_ff <= ZERO_A;
    end else begin
      lpm_grant_ff <= lpm_req & ~lpm_lock_block & ~lpm_rww_block;
      lpm_deny_ff  <= lpm_req & (lpm_lock_block | lpm_rww_block);
      irq_block_ff <= (vectors_in_boot & ~exec_boot & ~app_hi) |
                      (~vectors_in_boot & exec_boot & ~boot_hi);
      // Fuses are plain inputs, never written from here
      reset_vector_ff <= reset_vector_select_fuse ? ZERO_A : boot_start;
    end
  end

endmodule

// file: sim/bfsp_monitor.sv
// Port checker for the boot flash protection block.
// Assumes a bind from the bench top onto bfsp_top.
module bfsp_monitor #(
  parameter ADDR_W     = 14,
  parameter BOOT_MIN   = 256,
  parameter HALTING_REGION_WORDS = 2048
) (
  input wire              clock,
  input wire              sys_rst,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [1:0]        boot_region_size_fuses,
  input wire              reset_vector_select_fuse,
  input wire [ADDR_W-1:0] exec_pc,
  input wire              spm_req,
  input wire              lpm_req,
  input wire              lpm_grant_ff,
  input wire              lpm_deny_ff,
  input wire              cpu_halt_ff,
  input wire [ADDR_W-1:0] reset_vector_ff,
  input wire              flash_start_ff,
  input wire [ADDR_W-1:0] flash_addr_ff,
  input wire              flash_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [ADDR_W-1:0] bst;
  logic [ADDR_W-1:0] hst;
  logic [3:0]        since_ff;
  logic              run_ff;

  assign bst = '0 - (ADDR_W'(BOOT_MIN) << ~boot_region_size_fuses);
  assign hst = '0 - ADDR_W'(HALTING_REGION_WORDS);

  // Age of the last write response; flash operation in flight
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      since_ff <= 4'hf;
      run_ff   <= 1'b0;
    end else begin
      if (s_axi_bvalid)
        since_ff <= 4'h0;
      else if (since_ff != 4'hf)
        since_ff <= since_ff + 4'h1;
      if (flash_start_ff)
        run_ff <= 1'b1;
      else if (flash_done)
        run_ff <= 1'b0;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_RSTVEC: assert property (
    !sys_rst |=> reset_vector_ff ==
      ($past(reset_vector_select_fuse) ? '0 : $past(bst)))
    else $error("reset vector mismatch");
  AST_APP_SPM: assert property (
    spm_req && exec_pc < bst |=> !flash_start_ff)
    else $error("store from application started");
  AST_WINDOW: assert property (
    spm_req && !s_axi_bvalid && since_ff >= 4'h3 |=> !flash_start_ff)
    else $error("store outside window started");
  AST_BHOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_CAUSE: assert property (
    flash_start_ff |-> $past(spm_req) || $past(spm_req, 2))
    else $error("start without store");
  AST_ONE_OP: assert property (
    flash_start_ff |-> !run_ff)
    else $error("start during operation");
  AST_HALT_ON: assert property (
    flash_start_ff && flash_addr_ff >= hst |-> ##[0:1] cpu_halt_ff)
    else $error("no halt");
  AST_HALT_HOLD: assert property (
    run_ff && cpu_halt_ff && !flash_done |=> cpu_halt_ff)
    else $error("halt dropped early");
  AST_NO_HALT: assert property (
    flash_start_ff && flash_addr_ff < hst |=> !cpu_halt_ff)
    else $error("halt on concurrent region");
  AST_LPM_ANS: assert property (
    lpm_req |=> lpm_grant_ff != lpm_deny_ff)
    else $error("load answer wrong");

  cover property (flash_start_ff && flash_addr_ff >= hst);
  cover property (spm_req && exec_pc < bst);
  cover property (lpm_req ##1 lpm_deny_ff);
endmodule

// file: sim/bfsp_flash_model.sv
// Flash array model: ends each started operation after lat cycles.
// Assumes start is a one-cycle pulse and lat is at least four.
module bfsp_flash_model (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        start,
  input  wire [7:0]  lat,
  output logic       done_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff  <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (cnt_ff == 8'h01);
      if (start)
        cnt_ff <= lat;
      else if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule

// file: sim/test_boot_flash_section_protection.sv
// Self-checking random bench for the boot flash protection block.
// Assumes the design, monitor and flash model are compiled first.
module test_boot_flash_section_protection;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, sys_rst = 1, chip_erase = 0, vectors_in_boot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, spm_req = 0, lpm_req = 0;
  logic reset_vector_select_fuse = 0;
  logic [1:0] boot_region_size_fuses = 2'h3;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, spm_data = 0, lat = 16;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [13:0] exec_pc = 0, spm_addr = 0, lpm_addr = 0;
  logic [13:0] reset_vector_ff, flash_addr_ff, bs, pc, a;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, g;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, lpm_grant_ff, lpm_deny_ff, cpu_halt_ff, st, bsy;
  logic irq_block_ff, flash_start_ff, flash_erase_ff, flash_done;
  logic [7:0] cmd;
  logic [4:1] lk;
  int fail_count = 0, checks_done = 0;

  always #12.5 clock = ~clock;
  bfsp_top u_dut (.*);
  bfsp_flash_model u_flash (.clock(clock), .sys_rst(sys_rst),
    .start(flash_start_ff), .lat(lat), .done_ff(flash_done));

  function automatic bit inb(input logic [13:0] x);
    return x >= bs;
  endfunction
  function automatic bit lpm_ok(input logic [13:0] p, x);
    return !(inb(p) && !inb(x) && !lk[2]) && !(!inb(p) && inb(x) && !lk[4])
      && !(bsy && x < 14'h3800);
  endfunction

  task chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task axw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {ad, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task axr(input logic [7:0] ad);
    @(posedge clock);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
  endtask
  task program_store_instruction(input logic [13:0] p, x, input logic [7:0] c, d, input int gap);
    axw(8'h00, {24'h0, c});
    repeat (gap) @(posedge clock);
    {exec_pc, spm_addr, spm_data, spm_req} <= {p, x, d, 1'b1};
    @(posedge clock);
    spm_req <= 0;
    #1 st = flash_start_ff;
    @(posedge clock);
    #1 st = st | flash_start_ff;
  endtask
  task lpm(input logic [13:0] p, x);
    @(posedge clock);
    {exec_pc, lpm_addr, lpm_req} <= {p, x, 1'b1};
    @(posedge clock);
    lpm_req <= 0;
    #1 g = {lpm_grant_ff, lpm_deny_ff};
    chk("load", g, lpm_ok(p, x) ? 2'h2 : 2'h1);
    chk("irq", irq_block_ff, vectors_in_boot ? !inb(p) && !lk[2] : inb(p) && !lk[4]);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    conclude;
  end

  initial begin
    void'($urandom(32'hd3dcfd4e));
    repeat (5) @(posedge clock);
    sys_rst <= 0;
    {bs, lk, bsy} = {14'h3f00, 4'hf, 1'b0};
    axr(8'h04);
    chk("lock reset", rd, 32'h1f);
    chk("lock rresp", rsp, 2'h0);
    axw(8'h08, 32'h0);
    axr(8'h08);
    chk("cfg", rd[2:0], 3'h3);
    axw(8'h40, 32'h0);
    chk("unmapped", rsp, 2'h2);
    axr(8'h40);
    chk("unmapped rresp", rsp, 2'h2);
    chk("unmapped rdata", rd, 32'h0);
    program_store_instruction(bs, 14'h0100, 8'h03, 8'hff, 3);
    chk("late store", st, 1'b0);
    program_store_instruction(bs, 14'h0100, 8'h05, 8'hff, 2);
    chk("last window store", st, 1'b1);
    do @(posedge clock); while (!flash_done);
    repeat (2) @(posedge clock);
    program_store_instruction(bs, bs, 8'h09, 8'hfd, 0);
    program_store_instruction(bs, bs, 8'h09, 8'hff, 0);
    axr(8'h04);
    chk("lock sticky", rd, 32'h1d);
    for (int i = 0; i < 30; i++) begin
      {boot_region_size_fuses, reset_vector_select_fuse} <= 3'($urandom);
      {vectors_in_boot, chip_erase, lat} <= {1'($urandom), 1'b1, 8'd12 + 8'($urandom % 12)};
      @(posedge clock);
      chip_erase <= 0;
      {bs, lk} = {14'h0 - (14'h100 << ~boot_region_size_fuses), 4'hf};
      repeat (2) @(posedge clock);
      #1 chk("vector", reset_vector_ff, reset_vector_select_fuse ? 14'h0 : bs);
      program_store_instruction(bs, bs, 8'h11, 8'hff, 0);
      bsy = 0;
      cmd = 8'($urandom);
      program_store_instruction(bs, bs, 8'h09, cmd, 0);
      lk = cmd[4:1];
      repeat (3) begin
        {pc, a} = {14'($urandom), 14'($urandom)};
        pc = $urandom % 2 ? pc | bs : pc;
        lpm(pc, a);
        cmd = $urandom % 2 ? 8'h03 : 8'h05;
        program_store_instruction(pc, a, cmd, 8'hff, 0);
        chk("start", st, inb(pc) && (inb(a) ? lk[3] : lk[1]));
        if (st) begin
          chk("target", {flash_addr_ff, flash_erase_ff}, {a, cmd == 8'h03});
          @(posedge clock);
          #1 chk("halt", cpu_halt_ff, a >= 14'h3800);
          bsy = bsy | a < 14'h3800;
          if (a < 14'h3800) lpm(bs, a);
          do @(posedge clock); while (!flash_done);
          repeat (2) @(posedge clock);
        end
        axr(8'h00);
        chk("status", rd[7:6], {!st, bsy});
      end
    end
    conclude;
  end
endmodule

bind bfsp_top bfsp_monitor #(.ADDR_W(ADDR_W), .BOOT_MIN(BOOT_MIN),
  .HALTING_REGION_WORDS(HALTING_REGION_WORDS)) u_mon (.*);
